// ===== hdl/lnmc_pkg.sv
package lnmc_pkg;

    typedef enum logic [3:0]
    {
        ST_FAILSAFE = 4'h1,
        ST_NORMAL = 4'h2,
        ST_SILENT = 4'h4,
        ST_SLEEP = 4'h8
    } lnmc_state_t;

    typedef enum logic [1:0]
    {
        SRC_NONE = 2'h0,
        SRC_BUS = 2'h1,
        SRC_LOCAL = 2'h2,
        SRC_UV = 2'h3
    } lnmc_src_t;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int RESET_TIME_MS = 4;
    localparam int BUS_FILTER_TIME_US = 100;
    localparam int SLEEP_SKEW_NS = 3200;
    localparam logic [31:0] RESET_CYCLES = 32'((RESET_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [31:0] BUS_FILTER_CYCLES = 32'((BUS_FILTER_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [31:0] SLEEP_SKEW_CYCLES = 32'((SLEEP_SKEW_NS / CLK_PERIOD_NS > 0) ? SLEEP_SKEW_NS / CLK_PERIOD_NS : 1);
    localparam logic [31:0] MODE_WINDOW_CYCLES = 32'h00000010;
    localparam logic [31:0] LOCAL_WAKE_CYCLES = 32'h000003E8;
    localparam logic [31:0] DOM_TIMEOUT_CYCLES = 32'h000003E8;
    localparam logic [31:0] WDOG_CYCLES = 32'h000186A0;

    // ----------------------------------------
    // synchroniser bit positions and reset levels
    // ----------------------------------------
    localparam int SYNC_W = 9;
    localparam int I_EN = 0;
    localparam int I_TXD = 1;
    localparam int I_TRIG = 2;
    localparam int I_LWAKE = 3;
    localparam int I_BUS = 4;
    localparam int I_PREWAKE = 5;
    localparam int I_BATUV = 6;
    localparam int I_VCCUV = 7;
    localparam int I_HS = 8;
    localparam logic [8:0] SYNC_RESET = 9'h01E;

endpackage

// ===== hdl/lnmc_ctrl.sv
`timescale 1ns/1ps
module lnmc_ctrl
#(
    parameter logic [31:0] RESET_CYCLES = lnmc_pkg::RESET_CYCLES,
    parameter logic [31:0] BUS_FILTER_CYCLES = lnmc_pkg::BUS_FILTER_CYCLES,
    parameter logic [31:0] WDOG_CYCLES = lnmc_pkg::WDOG_CYCLES,
    parameter logic [31:0] LOCAL_WAKE_CYCLES = lnmc_pkg::LOCAL_WAKE_CYCLES,
    parameter logic [31:0] DOM_TIMEOUT_CYCLES = lnmc_pkg::DOM_TIMEOUT_CYCLES,
    parameter logic [31:0] MODE_WINDOW_CYCLES = lnmc_pkg::MODE_WINDOW_CYCLES
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // host pins
    input wire logic mode_select_in,
    input wire logic txd_in,
    output logic txd_out,
    output logic txd_oe,
    output logic rxd_out,
    input wire logic watchdog_trigger_n,
    output logic reset_out_n,
    // wake and supply monitors
    input wire logic local_wake_in,
    input wire logic bus_rx_in,
    input wire logic bus_prewake_threshold,
    input wire logic battery_undervoltage_threshold,
    input wire logic vcc_undervoltage_in,
    // high-side and limp-home
    input wire logic high_side_control_in,
    output logic high_side_out,
    output logic limp_home_out,
    // analog front-end controls
    output logic bus_drive_dominant,
    output logic bus_termination_on,
    output logic bus_receiver_on,
    output logic regulator_on,
    output logic watchdog_running,
    output lnmc_pkg::lnmc_state_t mode_state
);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [lnmc_pkg::SYNC_W-1:0] raw_in;
    logic [lnmc_pkg::SYNC_W-1:0] sync_a;
    logic [lnmc_pkg::SYNC_W-1:0] sync_b;
    logic [lnmc_pkg::SYNC_W-1:0] sync_prev;

    assign raw_in = {high_side_control_in, vcc_undervoltage_in, battery_undervoltage_threshold,
                     bus_prewake_threshold, bus_rx_in, local_wake_in, watchdog_trigger_n,
                     txd_in, mode_select_in};

    genvar g;
    generate
        for (g = 0; g < lnmc_pkg::SYNC_W; g = g + 1)
        begin : gen_sync
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    sync_a[g] <= lnmc_pkg::SYNC_RESET[g];
                    sync_b[g] <= lnmc_pkg::SYNC_RESET[g];
                    sync_prev[g] <= lnmc_pkg::SYNC_RESET[g];
                end
                else
                begin
                    sync_a[g] <= raw_in[g];
                    sync_b[g] <= sync_a[g];
                    sync_prev[g] <= sync_b[g];
                end
            end
        end
    endgenerate

    wire en_s = sync_b[lnmc_pkg::I_EN];
    wire txd_s = sync_b[lnmc_pkg::I_TXD];
    wire lw_s = sync_b[lnmc_pkg::I_LWAKE];
    wire bus_s = sync_b[lnmc_pkg::I_BUS];
    wire prewake_s = sync_b[lnmc_pkg::I_PREWAKE];
    wire bat_uv_s = sync_b[lnmc_pkg::I_BATUV];
    wire vcc_uv_s = sync_b[lnmc_pkg::I_VCCUV];
    wire hs_s = sync_b[lnmc_pkg::I_HS];
    wire en_fall = sync_prev[lnmc_pkg::I_EN] & ~en_s;
    wire trig_fall = sync_prev[lnmc_pkg::I_TRIG] & ~sync_b[lnmc_pkg::I_TRIG];
    wire lw_fall = sync_prev[lnmc_pkg::I_LWAKE] & ~lw_s;
    wire bus_rise = ~sync_prev[lnmc_pkg::I_BUS] & bus_s;

    // ----------------------------------------
    // state
    // ----------------------------------------
    lnmc_pkg::lnmc_state_t state;
    lnmc_pkg::lnmc_state_t next_state;
    lnmc_pkg::lnmc_src_t src;
    lnmc_pkg::lnmc_src_t next_src;
    logic [31:0] rst_timer;
    logic [31:0] next_rst_timer;
    logic [31:0] wd_cnt;
    logic [31:0] mode_cnt;
    logic [31:0] dom_cnt;
    logic [31:0] bus_cnt;
    logic [31:0] lw_cnt;
    logic uv_flag;
    logic txd_hi_all;
    logic txd_lo_all;
    logic rx_en;
    logic bus_armed;
    logic lw_armed;
    logic limp;
    logic next_limp;

    // ----------------------------------------
    // event decode
    // ----------------------------------------
    wire is_fs = state == lnmc_pkg::ST_FAILSAFE;
    wire is_normal = state == lnmc_pkg::ST_NORMAL;
    wire is_silent = state == lnmc_pkg::ST_SILENT;
    wire is_sleep = state == lnmc_pkg::ST_SLEEP;
    wire low_power = is_silent | is_sleep;
    wire timer_busy = rst_timer != 32'h0;
    wire wd_run = (is_normal | is_fs) & ~timer_busy;
    wire wd_expired = wd_run & (wd_cnt >= WDOG_CYCLES);
    // regulator is off in sleep, so its undervoltage flag means nothing there
    wire vcc_fail = vcc_uv_s & ~is_sleep;
    wire reset_evt = wd_expired | vcc_fail;
    wire bus_wake = low_power & rx_en & bus_armed & bus_rise & (bus_cnt > BUS_FILTER_CYCLES)
                    & (is_sleep | txd_s);
    wire local_wake = low_power & lw_armed & ~lw_s & (lw_cnt == LOCAL_WAKE_CYCLES);
    wire wake_evt = bus_wake | local_wake;
    wire mode_ok = is_normal | (is_fs & uv_flag & ~timer_busy);
    wire mode_done = mode_cnt == 32'h1;
    wire go_silent = mode_done & txd_hi_all & mode_ok;
    wire go_sleep = mode_done & txd_lo_all & mode_ok;
    wire dom_block = dom_cnt >= DOM_TIMEOUT_CYCLES;

    // ----------------------------------------
    // mode transitions
    // ----------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            lnmc_pkg::ST_FAILSAFE:
            begin
                if (timer_busy || reset_evt)
                    next_state = lnmc_pkg::ST_FAILSAFE;
                else if (go_sleep)
                    next_state = lnmc_pkg::ST_SLEEP;
                else if (go_silent)
                    next_state = lnmc_pkg::ST_SILENT;
                else if (en_s && !bat_uv_s && mode_cnt == 32'h0)
                    next_state = lnmc_pkg::ST_NORMAL;
            end
            lnmc_pkg::ST_NORMAL:
            begin
                if (reset_evt || bat_uv_s)
                    next_state = lnmc_pkg::ST_FAILSAFE;
                else if (go_sleep)
                    next_state = lnmc_pkg::ST_SLEEP;
                else if (go_silent)
                    next_state = lnmc_pkg::ST_SILENT;
            end
            lnmc_pkg::ST_SILENT:
            begin
                if (reset_evt || wake_evt || en_s)
                    next_state = lnmc_pkg::ST_FAILSAFE;
            end
            lnmc_pkg::ST_SLEEP:
            begin
                if (wake_evt || en_s)
                    next_state = lnmc_pkg::ST_FAILSAFE;
            end
            default:
                next_state = lnmc_pkg::ST_FAILSAFE;
        endcase
    end

    assign next_rst_timer = reset_evt ? RESET_CYCLES : (timer_busy ? rst_timer - 32'h1 : 32'h0);

    // hardware set wins over the clear in normal mode
    assign next_src = local_wake ? lnmc_pkg::SRC_LOCAL :
                      bus_wake ? lnmc_pkg::SRC_BUS :
                      (is_normal && bat_uv_s) ? lnmc_pkg::SRC_UV :
                      (is_normal && en_s) ? lnmc_pkg::SRC_NONE : src;

    assign next_limp = wd_expired ? 1'b1 :
                       (next_state == lnmc_pkg::ST_SLEEP) ? 1'b0 :
                       (is_normal && trig_fall) ? 1'b0 : limp;

    // ----------------------------------------
    // output decode from next values
    // ----------------------------------------
    wire next_fs = next_state == lnmc_pkg::ST_FAILSAFE;
    wire next_normal = next_state == lnmc_pkg::ST_NORMAL;
    wire next_sleep = next_state == lnmc_pkg::ST_SLEEP;
    wire next_silent = next_state == lnmc_pkg::ST_SILENT;
    wire src_txd_low = next_src == lnmc_pkg::SRC_BUS || next_src == lnmc_pkg::SRC_LOCAL;
    wire src_rxd_low = next_src == lnmc_pkg::SRC_BUS || next_src == lnmc_pkg::SRC_UV;
    // transmit pin only pulls low; its high level comes from the pull-up so the host can still drive it
    wire drv_txd_oe = (next_fs & src_txd_low) | next_sleep;
    wire drv_rxd = next_normal ? bus_s : next_fs ? ~src_rxd_low : next_silent;
    wire drv_dominant = next_normal & ~txd_s & ~dom_block;
    wire drv_reset_n = (next_rst_timer == 32'h0) & ~next_sleep;

    // ----------------------------------------
    // main registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= lnmc_pkg::ST_FAILSAFE;
            rst_timer <= RESET_CYCLES;
            src <= lnmc_pkg::SRC_NONE;
            limp <= 1'b0;
        end
        else
        begin
            state <= next_state;
            rst_timer <= next_rst_timer;
            src <= next_src;
            limp <= next_limp;
        end
    end

    // watchdog stops outside normal and fail-safe, and restarts on every falling trigger edge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            wd_cnt <= 32'h0;
        else if (!wd_run || trig_fall || reset_evt)
            wd_cnt <= 32'h0;
        else if (wd_cnt < WDOG_CYCLES)
            wd_cnt <= wd_cnt + 32'h1;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            uv_flag <= 1'b0;
        else if (is_normal && bat_uv_s)
            uv_flag <= 1'b1;
        else if (!is_fs)
            uv_flag <= 1'b0;
    end

    // mode window: the skew lead lets transmit fall late before it is sampled
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_cnt <= 32'h0;
            txd_hi_all <= 1'b0;
            txd_lo_all <= 1'b0;
        end
        else if (en_fall && mode_ok)
        begin
            mode_cnt <= lnmc_pkg::SLEEP_SKEW_CYCLES + MODE_WINDOW_CYCLES;
            txd_hi_all <= 1'b1;
            txd_lo_all <= 1'b1;
        end
        else if (en_s || !mode_ok)
            mode_cnt <= 32'h0;
        else if (mode_cnt != 32'h0)
        begin
            mode_cnt <= mode_cnt - 32'h1;
            if (mode_cnt <= MODE_WINDOW_CYCLES)
            begin
                txd_hi_all <= txd_hi_all & txd_s;
                txd_lo_all <= txd_lo_all & ~txd_s;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            dom_cnt <= 32'h0;
        else if (!is_normal || txd_s)
            dom_cnt <= 32'h0;
        else if (!dom_block)
            dom_cnt <= dom_cnt + 32'h1;
    end

    // ----------------------------------------
    // wake detectors
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_en <= 1'b0;
            bus_armed <= 1'b0;
            bus_cnt <= 32'h0;
        end
        else if (!low_power)
        begin
            rx_en <= 1'b0;
            bus_armed <= 1'b0;
            bus_cnt <= 32'h0;
        end
        else
        begin
            if (prewake_s)
                rx_en <= 1'b1;
            if (rx_en && bus_s)
            begin
                bus_armed <= ~bus_rise | bus_armed;
                bus_cnt <= 32'h0;
            end
            else if (rx_en && bus_armed && bus_cnt <= BUS_FILTER_CYCLES)
                bus_cnt <= bus_cnt + 32'h1;
        end
    end

    // a new local wake needs the pin to go high again before its next falling edge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lw_armed <= 1'b0;
            lw_cnt <= 32'h0;
        end
        else if (lw_s || !low_power)
        begin
            lw_armed <= 1'b0;
            lw_cnt <= 32'h0;
        end
        else if (lw_fall)
        begin
            lw_armed <= 1'b1;
            lw_cnt <= 32'h0;
        end
        else if (lw_armed && lw_cnt <= LOCAL_WAKE_CYCLES)
            lw_cnt <= lw_cnt + 32'h1;
    end

    // ----------------------------------------
    // output registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reset_out_n <= 1'b0;
            txd_out <= 1'b0;
            txd_oe <= 1'b0;
            rxd_out <= 1'b1;
            bus_drive_dominant <= 1'b0;
            bus_termination_on <= 1'b1;
            bus_receiver_on <= 1'b0;
            regulator_on <= 1'b1;
            watchdog_running <= 1'b0;
            high_side_out <= 1'b0;
            limp_home_out <= 1'b0;
            mode_state <= lnmc_pkg::ST_FAILSAFE;
        end
        else
        begin
            reset_out_n <= drv_reset_n;
            txd_out <= 1'b0;
            txd_oe <= drv_txd_oe;
            rxd_out <= drv_rxd;
            bus_drive_dominant <= drv_dominant;
            bus_termination_on <= next_fs | next_normal;
            bus_receiver_on <= next_normal | (rx_en & ~next_fs);
            regulator_on <= ~next_sleep;
            watchdog_running <= (next_fs | next_normal) & (next_rst_timer == 32'h0);
            high_side_out <= hs_s & ~next_sleep;
            limp_home_out <= next_limp;
            mode_state <= next_state;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    tx_only_normal_a:
    assert property (bus_drive_dominant |-> mode_state == lnmc_pkg::ST_NORMAL && rxd_out == $past(bus_s))
        else $error("bus driven outside normal mode");

    reset_to_fs_a:
    assert property ($fell(reset_out_n) |-> mode_state inside {lnmc_pkg::ST_FAILSAFE, lnmc_pkg::ST_SLEEP})
        else $error("reset low outside fail-safe");

    silent_outputs_a:
    assert property (mode_state == lnmc_pkg::ST_SILENT |-> !bus_drive_dominant && !bus_termination_on
                     && regulator_on && rxd_out)
        else $error("silent outputs wrong");

    sleep_outputs_a:
    assert property (mode_state == lnmc_pkg::ST_SLEEP |-> !regulator_on && !reset_out_n && !rxd_out
                     && !high_side_out && !limp_home_out)
        else $error("sleep outputs wrong");

    powerup_hold_a:
    assert property (timer_busy |-> !reset_out_n && state == lnmc_pkg::ST_FAILSAFE)
        else $error("reset released early");

    reset_ignore_a:
    assert property (is_fs && rst_timer > 32'h1 |=> state == lnmc_pkg::ST_FAILSAFE)
        else $error("mode change during reset");

    bus_source_a:
    assert property (bus_wake |=> txd_oe && !txd_out && !rxd_out && mode_state == lnmc_pkg::ST_FAILSAFE)
        else $error("bus wake source not signalled");

    wake_enters_fs_a:
    assert property (local_wake |=> state == lnmc_pkg::ST_FAILSAFE ##0 txd_oe && rxd_out)
        else $error("local wake not signalled");

    source_clear_a:
    assert property (is_normal && en_s && !bat_uv_s |=> src == lnmc_pkg::SRC_NONE)
        else $error("source not cleared");

    silent_txd_a:
    assert property (is_silent && !txd_s && !local_wake && !reset_evt && !en_s |=> is_silent)
        else $error("silent bus wake with transmit low");

    bus_filter_a:
    assert property (bus_wake |-> $past(bus_s == 1'b0, 1) && bus_cnt > BUS_FILTER_CYCLES)
        else $error("bus wake without full dominant phase");

endmodule

// ===== test/lnmc_host_model.sv
`timescale 1ns/1ps
module lnmc_host_model
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // bench controls
    input wire logic host_en,
    input wire logic host_txd,
    input wire logic trig_on,
    // device side
    input wire logic txd_oe,
    output logic mode_select_in,
    output logic txd_in,
    output logic watchdog_trigger_n
);
    logic [5:0] trig_cnt;

    // pin level: the device pull-down wins over the host drive
    assign txd_in = host_txd & ~txd_oe;
    // both pins move on one edge, so the skew is zero, inside the allowance
    assign mode_select_in = host_en;

    // ----------------------------------------
    // watchdog trigger, one low cycle every 64 cycles, well inside the timeout
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trig_cnt <= 6'h00;
            watchdog_trigger_n <= 1'b1;
        end
        else
        begin
            trig_cnt <= trig_cnt + 6'h01;
            watchdog_trigger_n <= !(trig_on && trig_cnt == 6'h00);
        end
    end
endmodule

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic host_en = 1'b1;
    logic host_txd = 1'b1;
    logic trig_on = 1'b1;
    logic local_wake_in = 1'b1;
    logic bus_rx_in = 1'b1;
    logic prewake = 1'b0;
    logic bat_uv = 1'b0;
    logic vcc_uv = 1'b0;
    logic hs_req = 1'b1;
    logic mode_select_in, txd_in, txd_out, txd_oe, rxd_out, watchdog_trigger_n, reset_out_n;
    logic high_side_out, limp_home_out, bus_drive_dominant, bus_termination_on, bus_receiver_on;
    logic regulator_on, watchdog_running;
    lnmc_pkg::lnmc_state_t mode_state;
    int mismatches = 0;
    int checks_done = 0;

    lnmc_ctrl #(.RESET_CYCLES(32'h00000032), .BUS_FILTER_CYCLES(32'h00000014), .WDOG_CYCLES(32'h000000C8),
        .LOCAL_WAKE_CYCLES(32'h0000000A), .DOM_TIMEOUT_CYCLES(32'h0000000A))
    lnmc_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .mode_select_in(mode_select_in), .txd_in(txd_in),
        .txd_out(txd_out), .txd_oe(txd_oe), .rxd_out(rxd_out), .watchdog_trigger_n(watchdog_trigger_n),
        .reset_out_n(reset_out_n), .local_wake_in(local_wake_in), .bus_rx_in(bus_rx_in),
        .bus_prewake_threshold(prewake), .battery_undervoltage_threshold(bat_uv),
        .vcc_undervoltage_in(vcc_uv), .high_side_control_in(hs_req), .high_side_out(high_side_out),
        .limp_home_out(limp_home_out), .bus_drive_dominant(bus_drive_dominant),
        .bus_termination_on(bus_termination_on), .bus_receiver_on(bus_receiver_on),
        .regulator_on(regulator_on), .watchdog_running(watchdog_running), .mode_state(mode_state));

    lnmc_host_model lnmc_host_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .host_en(host_en),
        .host_txd(host_txd), .trig_on(trig_on), .txd_oe(txd_oe), .mode_select_in(mode_select_in),
        .txd_in(txd_in), .watchdog_trigger_n(watchdog_trigger_n));

    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic finish_test();
        if (mismatches == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        #1;
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %0t %s", $time, what);
        end
        // return on a rising edge so the next stimulus lands on the edge
        @(posedge sys_clk);
    endtask

    // bounded wait; a limit that runs out is a mismatch
    task automatic wait_state(input lnmc_pkg::lnmc_state_t exp, input int limit);
        int n;
        n = 0;
        #1;
        while (mode_state !== exp && n < limit)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        checks_done++;
        if (mode_state !== exp)
        begin
            mismatches++;
            $display("MISMATCH %0t mode %0h", $time, mode_state);
        end
        @(posedge sys_clk);
    endtask

    task automatic bus_pulse(input int n);
        bus_rx_in <= 1'b0;
        cyc(n);
        bus_rx_in <= 1'b1;
        cyc(10);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_power_up();
        cyc(45);
        check_bit(reset_out_n, 1'b0, "reset hold");
        check_bit(regulator_on, 1'b1, "regulator at power-up");
        check_bit(bus_drive_dominant, 1'b0, "bus off at power-up");
        check_bit(mode_state === lnmc_pkg::ST_FAILSAFE, 1'b1, "request during hold");
        wait_state(lnmc_pkg::ST_NORMAL, 60);
        check_bit(reset_out_n, 1'b1, "reset released");
    endtask

    task automatic t_normal();
        host_txd <= 1'b0;
        cyc(6);
        check_bit(bus_drive_dominant, 1'b1, "tx drives bus");
        host_txd <= 1'b1;
        bus_rx_in <= 1'b0;
        hs_req <= 1'b0;
        cyc(6);
        check_bit(bus_drive_dominant, 1'b0, "tx released");
        check_bit(rxd_out, 1'b0, "rx follows bus");
        check_bit(high_side_out, 1'b0, "high-side follows request");
    endtask

    task automatic t_silent_bus_wake();
        host_en <= 1'b0;
        hs_req <= 1'b1;
        wait_state(lnmc_pkg::ST_SILENT, 400);
        // receiver on and bus recessive first, so the detector is armed before the tx-low pulse
        bus_rx_in <= 1'b1;
        prewake <= 1'b1;
        cyc(6);
        check_bit(bus_termination_on, 1'b0, "silent termination");
        check_bit(regulator_on, 1'b1, "silent regulator");
        check_bit(watchdog_running, 1'b0, "silent watchdog");
        check_bit(bus_receiver_on, 1'b1, "prewake receiver");
        check_bit(high_side_out, 1'b1, "silent high-side");
        host_txd <= 1'b0;
        bus_pulse(30);
        check_bit(mode_state === lnmc_pkg::ST_SILENT, 1'b1, "wake with tx low");
        host_txd <= 1'b1;
        bus_pulse(8);
        check_bit(mode_state === lnmc_pkg::ST_SILENT, 1'b1, "short dominant");
        bus_pulse(30);
        check_bit(mode_state === lnmc_pkg::ST_FAILSAFE, 1'b1, "bus wake");
        check_bit(txd_oe, 1'b1, "bus wake tx code");
        check_bit(txd_out, 1'b0, "bus wake tx pull-down");
        check_bit(rxd_out, 1'b0, "bus wake rx code");
        check_bit(bus_termination_on, 1'b1, "wake termination");
        prewake <= 1'b0;
        host_en <= 1'b1;
        wait_state(lnmc_pkg::ST_NORMAL, 20);
        check_bit(txd_oe, 1'b0, "source cleared");
    endtask

    task automatic t_sleep_local_wake();
        host_en <= 1'b0;
        host_txd <= 1'b0;
        wait_state(lnmc_pkg::ST_SLEEP, 400);
        cyc(4);
        check_bit(regulator_on, 1'b0, "sleep regulator");
        check_bit(reset_out_n, 1'b0, "sleep reset");
        check_bit(rxd_out, 1'b0, "sleep rx");
        check_bit(high_side_out, 1'b0, "sleep high-side");
        check_bit(limp_home_out, 1'b0, "sleep limp-home");
        local_wake_in <= 1'b0;
        cyc(5);
        local_wake_in <= 1'b1;
        cyc(10);
        check_bit(mode_state === lnmc_pkg::ST_SLEEP, 1'b1, "short local wake");
        local_wake_in <= 1'b0;
        wait_state(lnmc_pkg::ST_FAILSAFE, 30);
        check_bit(txd_oe, 1'b1, "local tx code");
        check_bit(rxd_out, 1'b1, "local rx code");
        local_wake_in <= 1'b1;
        host_txd <= 1'b1;
        host_en <= 1'b1;
        wait_state(lnmc_pkg::ST_NORMAL, 200);
    endtask

    task automatic t_undervoltage();
        bat_uv <= 1'b1;
        wait_state(lnmc_pkg::ST_FAILSAFE, 20);
        cyc(2);
        check_bit(txd_oe, 1'b0, "uv tx code");
        check_bit(rxd_out, 1'b0, "uv rx code");
        host_en <= 1'b0;
        wait_state(lnmc_pkg::ST_SILENT, 400);
        bat_uv <= 1'b0;
        vcc_uv <= 1'b1;
        wait_state(lnmc_pkg::ST_FAILSAFE, 20);
        check_bit(reset_out_n, 1'b0, "vcc uv reset");
        vcc_uv <= 1'b0;
        host_en <= 1'b1;
        wait_state(lnmc_pkg::ST_NORMAL, 200);
    endtask

    task automatic t_watchdog();
        trig_on <= 1'b0;
        wait_state(lnmc_pkg::ST_FAILSAFE, 300);
        check_bit(reset_out_n, 1'b0, "watchdog reset");
        check_bit(limp_home_out, 1'b1, "limp-home on expiry");
        trig_on <= 1'b1;
        wait_state(lnmc_pkg::ST_NORMAL, 200);
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        cyc(16);
        rst_n <= 1'b1;
        t_power_up();
        t_normal();
        t_silent_bus_wake();
        t_sleep_local_wake();
        t_undervoltage();
        t_watchdog();
        finish_test();
    end

    // the sequence needs about 1600 cycles; 100 us leaves a wide margin
    initial
    begin
        #100000;
        mismatches++;
        finish_test();
    end
endmodule
